// ==== rtl/four_level_irq_controller.sv ====
// four-level priority interrupt controller with vectoring and nesting
// How it works
// RL1 - hardware event sets pending flag regardless of its enable
// RL2 - enabled pending flag requests long call to vector after instruction
// RL3 - return resumes at the next instruction the core would have run
// RL4 - pending flag of a disabled source produces no request
// RL5 - per-source enables count only while global enable is one
// RL6 - global enable zero blocks every source
// RL7 - self-clearing sources lose their flag on vectoring
// RL8 - software clears other flags before returning
// RL9 - flag still set after return re-requests after one instruction
// RL10 - software write of one to a flag acts like an event
// RL11 - two priority bits per source, low and high registers
// RL12 - priority bits decode as binary level zero to three
// RL13 - all priorities reset to lowest level
// RL14 - only strictly higher level preempts; level three never preempted
// RL15 - highest level wins; ties go to lower vector position
// RL16 - requests sampled and decoded every clock
// RL17 - one clock detect plus four clock call, five total
// RL18 - after a return one instruction completes before the call
// RL19 - worst case covers detect, return, divide and call
// RL20 - equal or lower level waits for return plus one instruction
// RL21 - after return the highest pending request is served next
// RL22 - leaving high priority bits zero gives two-level behaviour
// RL23 - in-service record per level sets on vector, clears on return
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ns
module four_level_irq_controller
  import irq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [NUM_SRC-1:0] src_self_clear,
  input wire logic instr_done,
  input wire logic reti_done,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic call_active,
  output logic call_start,
  output logic [15:0] call_vector,
  output logic [SRC_W-1:0] call_src,
  output logic global_irq_enable
);
  // ---------------------------------------------------------------
  // source inputs: pins from outside pass two flops
  // ---------------------------------------------------------------
  // the two flops add two cycles ahead of the one detect cycle; only the
  // second flop feeds the pending flags
  logic [NUM_SRC-1:0] ev_meta_reg;
  logic [NUM_SRC-1:0] ev_sync_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_meta_reg <= '0;
      ev_sync_reg <= '0;
    end else begin
      ev_meta_reg <= src_event;
      ev_sync_reg <= ev_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [23:0] irq_enable_reg;
  logic [23:0] prio_low_bit_reg;
  logic [23:0] prio_high_bit_reg;
  logic [NUM_SRC-1:0] pend_reg;
  logic [NUM_LVL-1:0] in_service_reg;
  seq_state_t state_reg;
  logic [2:0] call_cnt_reg;
  logic [SRC_W-1:0] win_src_reg;
  logic [LVL_W-1:0] win_lvl_reg;
  logic [7:0] reg_rdata_reg;

  // software-visible byte index within a 24-bit group
  function automatic logic [1:0] grp_idx(input logic [3:0] a,
                                        input logic [3:0] base);
    logic [3:0] d;
    d = a - base;
    return d[1:0];
  endfunction

  // status and unmapped offsets fall through the chain: writes there are lost
  logic wr_en;
  logic wr_plo;
  logic wr_phi;
  logic wr_pend;
  always_comb begin
    wr_en = 1'b0;
    wr_plo = 1'b0;
    wr_phi = 1'b0;
    wr_pend = 1'b0;
    if (reg_wr && reg_addr <= OFF_ENABLE2) begin
      wr_en = 1'b1;
    end else if (reg_wr && reg_addr >= OFF_PRIO_LO0 &&
                 reg_addr <= OFF_PRIO_LO2) begin
      wr_plo = 1'b1;
    end else if (reg_wr && reg_addr >= OFF_PRIO_HI0 &&
                 reg_addr <= OFF_PRIO_HI2) begin
      wr_phi = 1'b1;
    end else if (reg_wr && reg_addr >= OFF_PEND0 &&
                 reg_addr <= OFF_PEND2) begin
      wr_pend = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_enable_reg <= {3{RESET_BYTE}};
    end else if (wr_en) begin
      irq_enable_reg[8*grp_idx(reg_addr, OFF_ENABLE0) +: 8] <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_low_bit_reg <= {3{RESET_BYTE}}; // RL13
      prio_high_bit_reg <= {3{RESET_BYTE}}; // RL13
    end else begin
      if (wr_plo) begin
        prio_low_bit_reg[8*grp_idx(reg_addr, OFF_PRIO_LO0) +: 8]
          <= reg_wdata; // RL11
      end
      if (wr_phi) begin
        prio_high_bit_reg[8*grp_idx(reg_addr, OFF_PRIO_HI0) +: 8]
          <= reg_wdata; // RL11
      end
    end
  end

  assign global_irq_enable = irq_enable_reg[GLOBAL_EN_BIT];

  // enable bit position per source: skip the global enable bit
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] src_plo;
  logic [NUM_SRC-1:0] src_phi;
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_map
      localparam int P = (g < GLOBAL_EN_BIT) ? g : g + 1;
      assign src_en[g] = irq_enable_reg[P];
      assign src_plo[g] = prio_low_bit_reg[P];
      assign src_phi[g] = prio_high_bit_reg[P];
    end
  endgenerate

  // ---------------------------------------------------------------
  // pending flags
  // ---------------------------------------------------------------
  logic vector_take;
  logic [NUM_SRC-1:0] pend_wmask;
  logic [NUM_SRC-1:0] pend_wval;
  always_comb begin
    pend_wmask = '0;
    pend_wval = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (wr_pend && (i < GLOBAL_EN_BIT ? i : i + 1) / 8 ==
          int'(grp_idx(reg_addr, OFF_PEND0))) begin
        pend_wmask[i] = 1'b1;
        pend_wval[i] = reg_wdata[(i < GLOBAL_EN_BIT ? i : i + 1) % 8];
      end
    end
  end

  // set wins over any clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (ev_sync_reg[i]) begin
          pend_reg[i] <= 1'b1; // RL1
        end else if (pend_wmask[i]) begin
          pend_reg[i] <= pend_wval[i]; // RL10
        end else if (vector_take && src_self_clear[i] &&
                     win_src_reg == SRC_W'(i)) begin
          pend_reg[i] <= 1'b0; // RL7
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // priority decode, every clock
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] req;
  logic any_req;
  logic [SRC_W-1:0] best_src;
  logic [LVL_W-1:0] best_lvl;
  logic [LVL_W-1:0] lvl_i;
  assign req = pend_reg & src_en &
               {NUM_SRC{global_irq_enable}}; // RL4 RL5 RL6
  always_comb begin
    any_req = 1'b0;
    best_src = '0;
    best_lvl = '0;
    lvl_i = '0;
    // scan from the top so lower positions win ties
    for (int i = NUM_SRC - 1; i >= 0; i--) begin // RL16
      lvl_i = {src_phi[i], src_plo[i]}; // RL12
      if (req[i] && (!any_req || lvl_i >= best_lvl)) begin // RL15
        any_req = 1'b1;
        best_src = SRC_W'(i);
        best_lvl = lvl_i;
      end
    end
  end

  // current threshold: highest level in service
  logic svc_any;
  logic [LVL_W-1:0] svc_lvl;
  always_comb begin
    svc_any = 1'b0;
    svc_lvl = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (in_service_reg[l]) begin
        svc_any = 1'b1;
        svc_lvl = LVL_W'(l);
      end
    end
  end

  // a return drops its own level from the threshold in the return cycle,
  // so a waiting request is detected during the return and the call
  // follows the very next instruction
  logic thr_any;
  logic [LVL_W-1:0] thr_lvl;
  always_comb begin
    thr_any = 1'b0;
    thr_lvl = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (in_service_reg[l] &&
          !(reti_done && LVL_W'(l) == svc_lvl)) begin // RL18 RL9
        thr_any = 1'b1;
        thr_lvl = LVL_W'(l);
      end
    end
  end

  logic can_preempt;
  assign can_preempt = any_req &&
    (!thr_any || (thr_lvl != LVL_TOP && best_lvl > thr_lvl)); // RL14 RL20

  // ---------------------------------------------------------------
  // call sequencer
  // ---------------------------------------------------------------
  // detection cycle latches the winner, then call when instruction ends;
  // the winner must still beat the threshold at that boundary, or a
  // request withdrawn during the hold would start a call with no routine
  assign vector_take = (state_reg == ST_HOLD) && instr_done &&
                       can_preempt; // RL2 RL9
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      call_cnt_reg <= '0;
      win_src_reg <= '0;
      win_lvl_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (can_preempt) begin // RL17
            state_reg <= ST_HOLD;
            win_src_reg <= best_src;
            win_lvl_reg <= best_lvl;
          end
        end
        ST_HOLD: begin
          if (!can_preempt) begin
            state_reg <= ST_IDLE;
          end else if (vector_take) begin
            state_reg <= ST_CALL;
            call_cnt_reg <= '0;
          end else begin
            // keep tracking the best until the call starts
            win_src_reg <= best_src; // RL21
            win_lvl_reg <= best_lvl;
          end
        end
        ST_CALL: begin
          if (call_cnt_reg == CALL_LAST) begin // RL17 RL19
            state_reg <= ST_IDLE;
          end else begin
            call_cnt_reg <= call_cnt_reg + 3'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // in-service record per level
  // ---------------------------------------------------------------
  // vectoring and return never meet in one cycle: a return is not an
  // instruction end, so the two branches below cannot collide
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_service_reg <= '0;
    end else if (vector_take) begin
      in_service_reg[win_lvl_reg] <= 1'b1; // RL23
    end else if (reti_done && svc_any) begin
      // return closes only the innermost (highest) level
      in_service_reg[svc_lvl] <= 1'b0; // RL23 RL3
    end
  end

  // ---------------------------------------------------------------
  // outputs to the sequencer
  // ---------------------------------------------------------------
  logic [15:0] vec_reg;
  logic [SRC_W-1:0] call_src_reg;
  logic call_start_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_reg <= '0;
      call_src_reg <= '0;
      call_start_reg <= 1'b0;
    end else begin
      call_start_reg <= vector_take;
      if (vector_take) begin
        vec_reg <= VEC_BASE +
          (16'(win_src_reg) << VEC_STEP_SHIFT); // RL2
        call_src_reg <= win_src_reg;
      end
    end
  end
  assign call_start = call_start_reg;
  assign call_vector = vec_reg;
  assign call_src = call_src_reg;
  assign call_active = (state_reg == ST_CALL);

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  // pending flags read back at their register bit positions, so a
  // read-modify-write by software keeps the neighbouring flags intact
  logic [23:0] pend_bytes;
  always_comb begin
    pend_bytes = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      pend_bytes[i < GLOBAL_EN_BIT ? i : i + 1] = pend_reg[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_reg <= '0;
    end else if (reg_rd) begin
      if (reg_addr <= OFF_ENABLE2) begin
        reg_rdata_reg <=
          irq_enable_reg[8*grp_idx(reg_addr, OFF_ENABLE0) +: 8];
      end else if (reg_addr <= OFF_PRIO_LO2) begin
        reg_rdata_reg <=
          prio_low_bit_reg[8*grp_idx(reg_addr, OFF_PRIO_LO0) +: 8];
      end else if (reg_addr <= OFF_PRIO_HI2) begin
        reg_rdata_reg <=
          prio_high_bit_reg[8*grp_idx(reg_addr, OFF_PRIO_HI0) +: 8];
      end else if (reg_addr <= OFF_PEND2) begin
        reg_rdata_reg <= pend_bytes[8*grp_idx(reg_addr, OFF_PEND0) +: 8];
      end else if (reg_addr == OFF_STATUS) begin
        reg_rdata_reg <= {2'h0, state_reg, in_service_reg};
      end else begin
        reg_rdata_reg <= '0;
      end
    end else begin
      reg_rdata_reg <= '0;
    end
  end
  assign reg_rdata = reg_rdata_reg;
endmodule

// ==== rtl/irq_ctrl_pkg.sv ====
// shared constants for the four-level interrupt controller
package irq_ctrl_pkg;
  // ---------------------------------------------------------------
  // sources and levels
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 20;
  localparam int SRC_W = 5;
  localparam int LVL_W = 2;
  localparam int NUM_LVL = 4;
  localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;
  // ---------------------------------------------------------------
  // vector table: base plus eight bytes per source position
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_STEP_SHIFT = 3;
  // ---------------------------------------------------------------
  // register offsets (8-bit data)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_ENABLE0 = 4'h0;
  localparam logic [3:0] OFF_ENABLE1 = 4'h1;
  localparam logic [3:0] OFF_ENABLE2 = 4'h2;
  localparam logic [3:0] OFF_PRIO_LO0 = 4'h3;
  localparam logic [3:0] OFF_PRIO_LO1 = 4'h4;
  localparam logic [3:0] OFF_PRIO_LO2 = 4'h5;
  localparam logic [3:0] OFF_PRIO_HI0 = 4'h6;
  localparam logic [3:0] OFF_PRIO_HI1 = 4'h7;
  localparam logic [3:0] OFF_PRIO_HI2 = 4'h8;
  localparam logic [3:0] OFF_PEND0 = 4'h9;
  localparam logic [3:0] OFF_PEND1 = 4'ha;
  localparam logic [3:0] OFF_PEND2 = 4'hb;
  localparam logic [3:0] OFF_STATUS = 4'hc;
  // bit 7 of the first enable register is the global enable
  localparam int GLOBAL_EN_BIT = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 4;
  localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);
  // ---------------------------------------------------------------
  // sequencer states, gray along hold -> call -> idle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01,
    ST_HOLD = 2'b11
  } seq_state_t;
endpackage

// ==== dv/irq_ctrl_monitor.sv ====
// port checker for the four-level interrupt controller
`timescale 1ns/1ns
module irq_ctrl_monitor
  import irq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_done,
  input wire logic reti_done,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic call_active,
  input wire logic call_start,
  input wire logic [15:0] call_vector,
  input wire logic [SRC_W-1:0] call_src,
  input wire logic global_irq_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic gbit;
  logic en0_wr;
  assign gbit = reg_wdata[GLOBAL_EN_BIT];
  assign en0_wr = reg_wr && reg_addr == OFF_ENABLE0;
  AST_CALL_LEN: assert property (
    $rose(call_active) |-> call_active [*4] ##1 !call_active)
    else $error("forced call length wrong");
  AST_START: assert property (
    call_start == $rose(call_active))
    else $error("call start pulse misplaced");
  AST_VECTOR: assert property (
    call_start |-> call_vector == VEC_BASE + (16'(call_src) << 3))
    else $error("vector does not match source");
  AST_TAKE: assert property (
    $rose(call_active) |-> $past(instr_done) && !$past(reti_done))
    else $error("call taken at wrong instruction");
  AST_GATE: assert property (
    $rose(call_active) |-> $past(global_irq_enable))
    else $error("call taken with global enable off");
  AST_GBIT: assert property (
    en0_wr |=> global_irq_enable == $past(gbit))
    else $error("global enable not written");
  AST_GHOLD: assert property (
    !en0_wr |=> $stable(global_irq_enable))
    else $error("global enable changed by itself");
  AST_HOLD: assert property (
    !call_start |-> $stable(call_src) && $stable(call_vector))
    else $error("call source changed between calls");
  COV_CALL: cover property (call_start);
  COV_RETI: cover property (reti_done ##[1:30] call_start);
  COV_GOFF: cover property ($fell(global_irq_enable));
endmodule

// ==== dv/cpu_model.sv ====
// behavioural core sequencer: instruction and return completions
`timescale 1ns/1ns
module cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic call_active,
  input wire logic [2:0] gap,
  input wire logic reti_req,
  output logic instr_done,
  output logic reti_done
);
  logic [2:0] cnt_reg;
  logic ret_reg;
  // the forced call owns the core, so nothing completes meanwhile
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 3'h0;
      ret_reg <= 1'b0;
      instr_done <= 1'b0;
      reti_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      reti_done <= 1'b0;
      if (call_active) cnt_reg <= gap;
      else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
      else begin
        // gap seven makes eight-cycle instructions, like a divide
        cnt_reg <= gap;
        instr_done <= !ret_reg;
        reti_done <= ret_reg;
        ret_reg <= 1'b0;
      end
      if (reti_req) ret_reg <= 1'b1;
    end
  end
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the four-level interrupt controller
`timescale 1ns/1ns
module testbench;
  import irq_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_SRC-1:0] src_event = '0;
  logic [NUM_SRC-1:0] src_self_clear = '0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reti_req = 1'b0;
  logic [2:0] gap = 3'h0;
  logic [7:0] reg_rdata, d;
  logic call_active, call_start, global_irq_enable, instr_done, reti_done;
  logic [15:0] call_vector, last_vec;
  logic [SRC_W-1:0] call_src, last_src;
  logic [7:0] sh [9];
  logic sc, bv;
  int failures, checked, cycles, calls, rets, s, a, b, w, l, k;
  int ic, ic_call, ret_cyc, lat;
  always #2 clk = ~clk;
  four_level_irq_controller u_four_level_irq_controller (.clk, .rst,
    .src_event, .src_self_clear, .instr_done, .reti_done, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .call_active, .call_start,
    .call_vector, .call_src, .global_irq_enable);
  cpu_model u_cpu_model (.clk, .rst, .call_active, .gap, .reti_req,
    .instr_done, .reti_done);
  always @(negedge clk) begin
    if (call_start === 1'b1) begin
      calls++;
      last_src = call_src;
      last_vec = call_vector;
      ic_call = ic;
      lat = cycles - ret_cyc;
    end
    if (instr_done === 1'b1) ic++;
    if (reti_done === 1'b1) begin
      rets++;
      ic = 0;
      ret_cyc = cycles;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int adr, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= 4'(adr);
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input int adr, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= 4'(adr);
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  // source position skips bit 7 of the first byte
  function automatic int pos(input int src);
    return (src < 7) ? src : src + 1;
  endfunction
  task automatic put(input int src, input int kind, input logic v);
    int i;
    i = kind * 3 + pos(src) / 8;
    sh[i][pos(src) % 8] = v;
    wr(i, sh[i]);
  endtask
  task automatic lvl(input int src, input logic [1:0] v);
    put(src, 1, v[0]);
    put(src, 2, v[1]);
  endtask
  task automatic glb(input logic v);
    sh[0][GLOBAL_EN_BIT] = v;
    wr(OFF_ENABLE0, sh[0]);
  endtask
  task automatic pbit(input int src, output logic v);
    rd(OFF_PEND0 + pos(src) / 8, d);
    v = d[pos(src) % 8];
  endtask
  task automatic pend(input int src, input logic v);
    rd(OFF_PEND0 + pos(src) / 8, d);
    d[pos(src) % 8] = v;
    wr(OFF_PEND0 + pos(src) / 8, d);
  endtask
  task automatic no_call(input int n);
    int c;
    c = calls;
    repeat (n) @(posedge clk);
    chk(16'(calls), 16'(c));
  endtask
  task automatic wait_call(input int src);
    int c;
    c = calls;
    repeat (80) if (calls == c) @(posedge clk);
    chk(16'(calls), 16'(c + 1));
    chk(16'(last_src), 16'(src));
    chk(last_vec, VEC_BASE + 16'(src) * 16'h0008);
  endtask
  task automatic reti();
    int c;
    c = rets;
    @(posedge clk);
    reti_req <= 1'b1;
    @(posedge clk);
    reti_req <= 1'b0;
    repeat (40) if (rets == c) @(posedge clk);
    chk(16'(rets), 16'(c + 1));
  endtask
  initial begin
    for (k = 0; k < 9; k++) sh[k] = 8'h00;
    void'($urandom(35));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // 0xd is unmapped and must read zero as well
    for (k = 0; k < 14; k++) begin
      rd(k, d);
      chk(16'(d), 16'(RESET_BYTE));
    end
    for (k = 0; k < 6; k++) begin
      @(posedge clk);
      s = $urandom_range(19, 0);
      sc = 1'($urandom_range(1, 0));
      gap <= 3'($urandom_range(7, 0));
      src_self_clear[s] <= sc;
      src_event[s] <= 1'b1;
      repeat (3) @(posedge clk);
      src_event[s] <= 1'b0;
      glb(1'b1);
      no_call(20);
      pbit(s, bv);
      chk(16'(bv), 16'h0001);
      glb(1'b0);
      put(s, 0, 1'b1);
      no_call(20);
      glb(1'b1);
      wait_call(s);
      pbit(s, bv);
      chk(16'(bv), 16'(!sc));
      if (!sc) begin
        reti();
        wait_call(s);
        chk(16'(ic_call), 16'h0001);
        chk(16'(lat), 16'(gap) + 16'h0002);
        pend(s, 1'b0);
      end
      reti();
      put(s, 0, 1'b0);
    end
    src_self_clear <= '0;
    for (l = 0; l < NUM_LVL; l++) begin
      a = $urandom_range(9, 0);
      b = a + 1 + $urandom_range(9, 0);
      w = (l == 0) ? a : b;
      glb(1'b0);
      lvl(b, 2'(l));
      lvl(a, 2'((l == 0) ? 0 : l - 1));
      put(a, 0, 1'b1);
      put(b, 0, 1'b1);
      pend(a, 1'b1);
      pend(b, 1'b1);
      glb(1'b1);
      wait_call(w);
      pend(w, 1'b0);
      reti();
      wait_call(a + b - w);
      pend(a + b - w, 1'b0);
      reti();
      lvl(a, 2'h0);
      lvl(b, 2'h0);
      put(a, 0, 1'b0);
      put(b, 0, 1'b0);
    end
    // lower index at equal level must still not preempt
    for (l = 0; l < NUM_LVL; l++) begin
      a = $urandom_range(19, 10);
      b = $urandom_range(9, 0);
      lvl(a, 2'(l));
      lvl(b, 2'(l));
      put(a, 0, 1'b1);
      put(b, 0, 1'b1);
      pend(a, 1'b1);
      wait_call(a);
      pend(a, 1'b0);
      pend(b, 1'b1);
      no_call(30);
      if (l < 3) begin
        lvl(b, 2'(l + 1));
        wait_call(b);
        pend(b, 1'b0);
        reti();
      end
      reti();
      if (l == 3) begin
        wait_call(b);
        pend(b, 1'b0);
        reti();
      end
      lvl(a, 2'h0);
      lvl(b, 2'h0);
      put(a, 0, 1'b0);
      put(b, 0, 1'b0);
    end
    wrap_up();
  end
endmodule
bind four_level_irq_controller irq_ctrl_monitor u_irq_ctrl_monitor (
  .clk, .rst, .instr_done, .reti_done, .reg_addr, .reg_wdata, .reg_wr,
  .call_active, .call_start, .call_vector, .call_src, .global_irq_enable);
